// ### design/cpu_defines.svh
// Constants for the compare and PWM unit
`ifndef CPU_DEFINES_SVH
`define CPU_DEFINES_SVH
// Functional notes
// R1: Software sets the pin as output before using compare.
// R2: Writing zero to control clears the compare output latch low.
// R3: Software runs the first timer synchronously during compare.
// R4: Software-interrupt mode 1010 only raises the flag, pin untouched.
// R5: Special-event mode 1011 resets first timer, starts conversion if enabled.
// R6: Trigger asserts at match; timer clears at next timer clock edge.
// R7: Value pair acts as first timer's programmable period in special-event mode.
// R8: Trigger-caused timer reset never sets the timer overflow flag.
// R9: Match removed before the reset edge cancels the timer reset.
// R10: While sleeping, no compare matches are produced.
// R11: Pin function moves to an alternate pin by a select bit.
// R12: Standard PWM gives up to ten bits of duty resolution.
// R13: Period, duty and resolution come from period, timer control, value, control.
// R14: Software clears the direction bit so the PWM appears on the pin.
// R15: Clearing control during PWM releases the output pin.
// R16: Compare mode checks the value pair against the first timer continuously.
// R17: A match sets, clears or toggles the output and sets the event flag.
// R18: After timer equals period: timer clears, pin rises unless duty zero, duty latched.
// R19: Pin clears when ten-bit time base equals latched duty.
`define CPU_A_CTRL 3'h0
`define CPU_A_VLO 3'h1
`define CPU_A_VHI 3'h2
`define CPU_A_PER 3'h3
`define CPU_A_T2C 3'h4
`define CPU_A_MISC 3'h5
`define CPU_A_STAT 3'h6
`define CPU_A_MASK 3'h7
`define CPU_PER_RST 8'hff
`define CPU_ST_EVT 0
`define CPU_ST_T1OV 1
`define CPU_ST_T2M 2
`endif

// ### design/cpu_pkg.sv
// Types for the compare and PWM unit
package cpu_pkg;
    typedef enum logic [3:0] {
        CPU_OFF = 4'h0,
        CPU_CMP_TOG = 4'h2,
        CPU_CMP_SET = 4'h8,
        CPU_CMP_CLR = 4'h9,
        CPU_CMP_SWI = 4'ha,
        CPU_CMP_SEV = 4'hb
    } cpu_mode_t;
    typedef enum logic [1:0] {
        CPU_S_IDLE = 2'b00,
        CPU_S_CMP = 2'b01,
        CPU_S_PWM = 2'b10
    } cpu_state_t;
endpackage : cpu_pkg

// ### design/cpu_sync.sv
// Two-flip-flop synchroniser bank
`timescale 1ns/1ps
`default_nettype none
module cpu_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (srst) begin
                    s1_q[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else if (ce) begin
                    s1_q[i] <= d[i];
                    q[i] <= s1_q[i];
                end
            end
        end
    endgenerate
endmodule : cpu_sync
`default_nettype wire

// ### design/cpu_top.sv
// Compare and standard PWM unit with register port
`timescale 1ns/1ps
`default_nettype none
`include "cpu_defines.svh"
module cpu_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    input wire logic sleep_pin,
    input wire logic adc_enable,
    input wire logic t1_tick,
    output logic [15:0] t1_count,
    output logic t1_overflow,
    output logic special_trigger,
    output logic adc_start,
    output logic unit_output_pin_o,
    output logic unit_output_pin_oe,
    output logic alt_output_pin_o,
    output logic alt_output_pin_oe,
    output logic irq
);
    import cpu_pkg::*;
    logic [7:0] ctrl_q;
    logic [7:0] vlo_q;
    logic [7:0] vhi_q;
    logic [7:0] per_q;
    logic [7:0] t2c_q;
    logic [1:0] misc_q;
    logic [2:0] stat_q;
    logic [2:0] mask_q;
    logic [7:0] t2_q;
    logic [1:0] t2x_q;
    logic [3:0] pre_q;
    logic [1:0] dlat_q;
    logic cmp_latch_q;
    logic pwm_q;
    logic sev_pend_q;
    logic match_q;
    logic [1:0] sync_q;
    logic sleeping;
    logic t1_edge;
    cpu_mode_t mode;
    cpu_state_t state;
    logic ctrl_wr;
    logic match;
    logic t1_wrap;
    logic t2_inc;
    logic t2_end;
    logic [9:0] tbase;
    logic [9:0] duty_lat;
    logic [2:0] ev;
    logic [3:0] pre_max;

    // Sleep and tick arrive from other clock sources
    cpu_sync #(.W(2)) u_sync (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .d({sleep_pin, t1_tick}),
        .q(sync_q)
    );
    assign sleeping = sync_q[1];
    assign t1_edge = sync_q[0] & ~sleeping;

    assign mode = cpu_mode_t'(ctrl_q[3:0]);
    assign ctrl_wr = wr_en && addr == `CPU_A_CTRL;
    always_comb begin
        if (ctrl_q[3:2] == 2'b11) begin
            state = CPU_S_PWM;
        end else if (ctrl_q[3] || ctrl_q[3:0] == 4'h2) begin
            state = CPU_S_CMP;
        end else begin
            state = CPU_S_IDLE;
        end
    end

    // Continuous 16-bit compare, suppressed while asleep [R16] [R10]
    assign match = state == CPU_S_CMP && !sleeping && t1_count == {vhi_q, vlo_q};

    // Register writes [R13]
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl_q <= 8'h00;
            vlo_q <= 8'h00;
            per_q <= `CPU_PER_RST;
            t2c_q <= 8'h00;
            misc_q <= 2'b00;
            mask_q <= 3'h0;
        end else if (ce && wr_en) begin
            case (addr)
                `CPU_A_CTRL: ctrl_q <= wdata;
                `CPU_A_VLO: vlo_q <= wdata;
                `CPU_A_PER: per_q <= wdata;
                `CPU_A_T2C: t2c_q <= wdata;
                `CPU_A_MISC: misc_q <= wdata[1:0];
                `CPU_A_MASK: mask_q <= wdata[2:0];
                default: ;
            endcase
        end
    end

    // High value byte is read-only in PWM, loaded with duty at period end
    always_ff @(posedge clk) begin
        if (srst) begin
            vhi_q <= 8'h00;
            dlat_q <= 2'b00;
        end else if (ce) begin
            if (state == CPU_S_PWM && t2_end) begin
                vhi_q <= vlo_q; // [R18]
                dlat_q <= ctrl_q[5:4];
            end else if (wr_en && addr == `CPU_A_VHI && state != CPU_S_PWM) begin
                vhi_q <= wdata;
            end
        end
    end

    // First timer; special event reset waits for the next timer edge
    assign t1_wrap = t1_edge && t1_count == 16'hffff;
    always_ff @(posedge clk) begin
        if (srst) begin
            t1_count <= 16'h0000;
            sev_pend_q <= 1'b0;
        end else if (ce) begin
            if (match && mode == CPU_CMP_SEV) begin
                sev_pend_q <= 1'b1; // [R6]
            end else if (!match) begin
                sev_pend_q <= 1'b0; // [R9]
            end
            if (t1_edge) begin
                if (sev_pend_q && match) begin
                    t1_count <= 16'h0000; // [R5] [R7]
                    sev_pend_q <= 1'b0;
                end else begin
                    t1_count <= t1_count + 16'h0001;
                end
            end
        end
    end
    // Overflow only from real wrap, never from the trigger reset [R8]
    assign t1_overflow = t1_wrap && !(sev_pend_q && match);

    // Trigger is combinational on the match itself [R6] [R5]
    assign special_trigger = match && mode == CPU_CMP_SEV;
    assign adc_start = special_trigger && adc_enable && !match_q;

    // Compare output latch; zero control forces it low [R2] [R17] [R4]
    always_ff @(posedge clk) begin
        if (srst) begin
            cmp_latch_q <= 1'b0;
            match_q <= 1'b0;
        end else if (ce) begin
            match_q <= match;
            if (ctrl_wr && wdata == 8'h00) begin
                cmp_latch_q <= 1'b0; // [R2]
            end else if (match && !match_q) begin
                case (mode)
                    CPU_CMP_SET: cmp_latch_q <= 1'b1; // [R17]
                    CPU_CMP_CLR: cmp_latch_q <= 1'b0;
                    CPU_CMP_TOG: cmp_latch_q <= ~cmp_latch_q;
                    default: cmp_latch_q <= cmp_latch_q; // [R4]
                endcase
            end
        end
    end

    // Second timer with prescaler; 2 extra bits extend the time base [R12]
    always_comb begin
        case (t2c_q[1:0])
            2'b00: pre_max = 4'h0;
            2'b01: pre_max = 4'h3;
            default: pre_max = 4'hf;
        endcase
    end
    assign t2_inc = t2c_q[2] && !sleeping && t2x_q == 2'b11 && pre_q == pre_max;
    assign t2_end = t2_inc && t2_q == per_q;
    always_ff @(posedge clk) begin
        if (srst) begin
            t2_q <= 8'h00;
            t2x_q <= 2'b00;
            pre_q <= 4'h0;
        end else if (ce && t2c_q[2] && !sleeping) begin
            // Tick counts system clocks; the prescaler slows the time base
            if (pre_q == pre_max) begin
                pre_q <= 4'h0;
                t2x_q <= t2x_q + 2'b01;
            end else begin
                pre_q <= pre_q + 4'h1;
            end
            if (t2_inc) begin
                t2_q <= t2_end ? 8'h00 : t2_q + 8'h01; // [R18]
            end
        end
    end
    // Low two time-base bits step once per prescaled clock, so one duty step lasts that long
    assign tbase = {t2_q, t2x_q};
    // The pin falls as the base steps onto the duty value, giving exactly duty steps high
    logic tb_step;
    logic [9:0] tbase_nx;
    assign tb_step = t2c_q[2] && !sleeping && pre_q == pre_max;
    assign tbase_nx = tbase + 10'h001;
    assign duty_lat = {vhi_q, dlat_q};

    // PWM output flop
    always_ff @(posedge clk) begin
        if (srst) begin
            pwm_q <= 1'b0;
        end else if (ce) begin
            if (state != CPU_S_PWM) begin
                pwm_q <= 1'b0;
            end else if (t2_end) begin
                pwm_q <= {vlo_q, ctrl_q[5:4]} != 10'h000; // [R18]
            end else if (tb_step && tbase_nx == duty_lat) begin
                pwm_q <= 1'b0; // [R19]
            end
        end
    end

    // Pin drive: off, software-interrupt and special-event release the pin [R4] [R5] [R15]
    logic drive;
    logic level;
    assign drive = (state == CPU_S_PWM) ||
        (state == CPU_S_CMP && mode != CPU_CMP_SWI && mode != CPU_CMP_SEV);
    assign level = (state == CPU_S_PWM) ? pwm_q : cmp_latch_q;
    // Direction bit belongs to the port; it is ANDed here as the pad gate
    assign unit_output_pin_o = level;
    assign unit_output_pin_oe = drive && !misc_q[1] && !misc_q[0]; // [R11] [R14] [R1]
    assign alt_output_pin_o = level;
    assign alt_output_pin_oe = drive && !misc_q[1] && misc_q[0]; // [R11]

    // Sticky flags, set wins over write-one clear
    assign ev = {t2_end, t1_overflow, match && !match_q}; // [R17] [R3]
    always_ff @(posedge clk) begin
        if (srst) begin
            stat_q <= 3'h0;
        end else if (ce) begin
            if (wr_en && addr == `CPU_A_STAT) begin
                stat_q <= (stat_q & ~wdata[2:0]) | ev;
            end else begin
                stat_q <= stat_q | ev;
            end
        end
    end
    assign irq = |(stat_q & mask_q);

    // Read port, data one cycle later
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 8'h00;
        end else if (ce) begin
            if (rd_en) begin
                case (addr)
                    `CPU_A_CTRL: rdata <= ctrl_q;
                    `CPU_A_VLO: rdata <= vlo_q;
                    `CPU_A_VHI: rdata <= vhi_q;
                    `CPU_A_PER: rdata <= per_q;
                    `CPU_A_T2C: rdata <= t2c_q;
                    `CPU_A_MISC: rdata <= {6'h00, misc_q};
                    `CPU_A_STAT: rdata <= {5'h00, stat_q};
                    `CPU_A_MASK: rdata <= {5'h00, mask_q};
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end

    AST_ZERO_CLEARS: assert property (@(posedge clk) disable iff (srst) // [R2]
        ce && ctrl_wr && wdata == 8'h00 |=> !cmp_latch_q)
        else $error("Latch not low after zero control");
    AST_SWI_NO_PIN: assert property (@(posedge clk) disable iff (srst) // [R4]
        mode == CPU_CMP_SWI |-> !unit_output_pin_oe && !alt_output_pin_oe)
        else $error("Pin driven in software interrupt mode");
    AST_SEV_NO_PIN: assert property (@(posedge clk) disable iff (srst) // [R5]
        mode == CPU_CMP_SEV |-> !unit_output_pin_oe && !alt_output_pin_oe)
        else $error("Pin driven in special event mode");
    AST_SEV_TRIG: assert property (@(posedge clk) disable iff (srst) // [R6]
        match && mode == CPU_CMP_SEV |-> special_trigger)
        else $error("Trigger missing on match");
    AST_SEV_RESET: assert property (@(posedge clk) disable iff (srst) // [R7]
        ce && sev_pend_q && match && t1_edge |=> t1_count == 16'h0000)
        else $error("Timer not reset by trigger");
    AST_NO_OVF: assert property (@(posedge clk) disable iff (srst) // [R8]
        sev_pend_q && match |-> !t1_overflow)
        else $error("Overflow on trigger reset");
    AST_CANCEL: assert property (@(posedge clk) disable iff (srst) // [R9]
        ce && t1_edge && !match && t1_count != 16'hffff |=> t1_count == $past(t1_count) + 16'h0001)
        else $error("Timer reset without match");
    AST_SLEEP: assert property (@(posedge clk) disable iff (srst) // [R10]
        sleeping |-> !match)
        else $error("Match while sleeping");
    AST_RELEASE: assert property (@(posedge clk) disable iff (srst) // [R15]
        ctrl_q == 8'h00 |-> !unit_output_pin_oe && !alt_output_pin_oe)
        else $error("Pin held with control cleared");
    AST_PWM_RISE: assert property (@(posedge clk) disable iff (srst) // [R18]
        ce && state == CPU_S_PWM && t2_end && {vlo_q, ctrl_q[5:4]} != 10'h000 |=> pwm_q)
        else $error("PWM did not rise at period end");
    AST_PWM_FALL: assert property (@(posedge clk) disable iff (srst) // [R19]
        ce && state == CPU_S_PWM && !t2_end && tb_step && tbase_nx == duty_lat |=> !pwm_q)
        else $error("PWM did not fall at duty match");
    AST_EVT_FLAG: assert property (@(posedge clk) disable iff (srst) // [R17]
        ce && match && !match_q |=> stat_q[`CPU_ST_EVT])
        else $error("Event flag not set on match");
    AST_PWM_LATCH: assert property (@(posedge clk) disable iff (srst) // [R18]
        ce && state == CPU_S_PWM && t2_end |=> vhi_q == $past(vlo_q))
        else $error("Duty not latched at period end");
    AST_T2_CLEAR: assert property (@(posedge clk) disable iff (srst) // [R18]
        ce && t2_end |=> t2_q == 8'h00)
        else $error("Second timer not cleared at period end");
    AST_PWM_ZERO: assert property (@(posedge clk) disable iff (srst) // [R18]
        ce && state == CPU_S_PWM && t2_end && {vlo_q, ctrl_q[5:4]} == 10'h000 |=> !pwm_q)
        else $error("PWM rose with zero duty");
    AST_VHI_RO: assert property (@(posedge clk) disable iff (srst) // [R13]
        ce && state == CPU_S_PWM && !t2_end && wr_en && addr == `CPU_A_VHI |=> vhi_q == $past(vhi_q))
        else $error("High value byte written in PWM mode");
    AST_ALT_EXCL: assert property (@(posedge clk) disable iff (srst) // [R11]
        !(unit_output_pin_oe && alt_output_pin_oe))
        else $error("Both pin locations driven");
    AST_SET_PIN: assert property (@(posedge clk) disable iff (srst) // [R17]
        ce && match && !match_q && mode == CPU_CMP_SET && !ctrl_wr |=> cmp_latch_q)
        else $error("Set mode did not raise the latch");
    AST_CLR_PIN: assert property (@(posedge clk) disable iff (srst) // [R17]
        ce && match && !match_q && mode == CPU_CMP_CLR && !ctrl_wr |=> !cmp_latch_q)
        else $error("Clear mode did not lower the latch");
    AST_TOG_PIN: assert property (@(posedge clk) disable iff (srst) // [R17]
        ce && match && !match_q && mode == CPU_CMP_TOG && !ctrl_wr |=> cmp_latch_q != $past(cmp_latch_q))
        else $error("Toggle mode did not invert the latch");
    AST_SWI_HOLD: assert property (@(posedge clk) disable iff (srst) // [R4]
        ce && match && mode == CPU_CMP_SWI && !ctrl_wr |=> cmp_latch_q == $past(cmp_latch_q))
        else $error("Latch moved in software interrupt mode");
    AST_SLEEP_T1: assert property (@(posedge clk) disable iff (srst) // [R10]
        ce && sleeping |=> t1_count == $past(t1_count))
        else $error("First timer moved while asleep");
    COV_SEV: cover property (@(posedge clk) special_trigger ##[1:20] t1_count == 16'h0000);
    COV_TOG: cover property (@(posedge clk) mode == CPU_CMP_TOG && match && !match_q);
    COV_PWM: cover property (@(posedge clk) state == CPU_S_PWM && pwm_q ##[1:200] !pwm_q);
    COV_IRQ: cover property (@(posedge clk) irq);
    COV_ALT: cover property (@(posedge clk) alt_output_pin_oe && alt_output_pin_o);
endmodule : cpu_top
`default_nettype wire

// ### tb/cpu_load.sv
// Pull-down load on the unit output pin
`timescale 1ns/1ps
`default_nettype none
module cpu_load (
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic pin_level
);
    // A released pin falls to the pull-down, never holds the last driven value
    assign pin_level = pin_oe ? pin_o : 1'b0;
endmodule : cpu_load
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the compare and PWM unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cpu_pkg::*;
    logic clk = 0, srst = 1, ce = 1, wr_en = 0, rd_en = 0;
    logic sleep_pin = 0, adc_enable = 0, t1_tick = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata;
    logic [15:0] t1_count;
    logic t1_overflow, special_trigger, adc_start, pin_o, pin_oe, alt_o, alt_oe, irq, pin_lvl;
    logic adc_seen = 0, ov_seen = 0;
    int miscompares = 0, n_checks = 0;
    always #2 clk = ~clk;
    always @(posedge clk) begin
        if (srst) begin
            adc_seen <= 1'b0;
            ov_seen <= 1'b0;
        end else begin
            if (adc_start === 1'b1) adc_seen <= 1'b1;
            if (t1_overflow === 1'b1) ov_seen <= 1'b1;
        end
    end
    cpu_top cpu_top_inst (.clk(clk), .srst(srst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .sleep_pin(sleep_pin),
        .adc_enable(adc_enable), .t1_tick(t1_tick), .t1_count(t1_count),
        .t1_overflow(t1_overflow), .special_trigger(special_trigger), .adc_start(adc_start),
        .unit_output_pin_o(pin_o), .unit_output_pin_oe(pin_oe), .alt_output_pin_o(alt_o),
        .alt_output_pin_oe(alt_oe), .irq(irq));
    cpu_load cpu_load_inst (.pin_o(pin_o), .pin_oe(pin_oe), .pin_level(pin_lvl));
    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic results;
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
        @(posedge clk);
    endtask : rd
    task automatic do_reset;
        srst <= 1'b1;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    // Pulsed ticks with a gap so each one survives the synchroniser as one step
    task automatic tick_n(input int n);
        repeat (n) begin
            t1_tick <= 1'b1; // Timer clock kept synchronous to the system clock
            @(posedge clk);
            t1_tick <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask : tick_n
    task automatic reg_defaults;
        logic [7:0] d;
        do_reset;
        rd(3'h0, d); check("control", d, 0);
        rd(3'h3, d); check("period", d, 16'h00ff);
        rd(3'h6, d); check("status", d, 0);
        wr(3'h7, 8'h05);
        rd(3'h7, d); check("mask", d, 16'h0005);
    endtask : reg_defaults
    task automatic cmp_mode(input cpu_mode_t m, input logic exp_pin, input logic exp_oe);
        logic [7:0] d;
        do_reset;
        wr(3'h5, 8'h00); // Direction bit cleared: pin is an output
        wr(3'h1, 8'h10);
        wr(3'h2, 8'h00);
        wr(3'h0, {4'h0, m});
        tick_n(16);
        check("count", t1_count, 16'h0010);
        check("pin", pin_lvl, {15'h0, exp_pin});
        check("pin oe", pin_oe, {15'h0, exp_oe});
        check("irq masked", irq, 0);
        wr(3'h7, 8'h01);
        check("irq", irq, 1);
        wr(3'h6, 8'h01);
        rd(3'h6, d); check("status", d, 0);
        check("irq off", irq, 0);
        wr(3'h0, 8'h00);
        check("latch low", pin_o, 0);
    endtask : cmp_mode
    task automatic special_event;
        logic [7:0] d;
        do_reset;
        adc_enable <= 1'b1;
        wr(3'h1, 8'h08);
        wr(3'h0, {4'h0, CPU_CMP_SEV});
        tick_n(8);
        check("trigger", special_trigger, 1);
        check("count held", t1_count, 16'h0008);
        check("adc start", adc_seen, 1);
        check("pin oe", pin_oe, 0);
        tick_n(1);
        check("count reset", t1_count, 0);
        tick_n(9);
        check("second period", t1_count, 0);
        check("overflow", ov_seen, 0);
        rd(3'h6, d); check("t1 flag", {15'h0, d[1]}, 0);
        tick_n(8);
        wr(3'h1, 8'h40);
        tick_n(1);
        check("no reset", t1_count, 16'h0009);
        adc_enable <= 1'b0;
    endtask : special_event
    task automatic asleep;
        logic [7:0] d;
        do_reset;
        sleep_pin <= 1'b1;
        wr(3'h1, 8'h00);
        wr(3'h0, {4'h0, CPU_CMP_SET});
        tick_n(6);
        rd(3'h6, d); check("sleep flag", {15'h0, d[0]}, 0);
        check("sleep pin", pin_lvl, 0);
        sleep_pin <= 1'b0;
        repeat (4) @(posedge clk);
        rd(3'h6, d); check("wake flag", {15'h0, d[0]}, 16'h0001);
    endtask : asleep
    task automatic alt_pin;
        do_reset;
        wr(3'h5, 8'h01);
        wr(3'h1, 8'h02);
        wr(3'h0, {4'h0, CPU_CMP_SET});
        tick_n(2);
        check("alt pin", {alt_oe, alt_o}, 16'h0003);
        check("main oe", pin_oe, 0);
    endtask : alt_pin
    // Counting over whole periods makes the figure independent of phase
    task automatic pwm_run(input logic [7:0] t2c, lo, ctl, input int win, input int exp_n);
        int n;
        logic [7:0] d;
        do_reset;
        wr(3'h5, 8'h00); // Direction bit cleared so the waveform reaches the pin
        wr(3'h3, 8'h03);
        wr(3'h1, lo);
        wr(3'h0, ctl);
        wr(3'h4, t2c);
        repeat (2 * win) @(posedge clk);
        n = 0;
        repeat (win) begin
            @(posedge clk);
            #1 if (pin_lvl === 1'b1) n++;
        end
        check("pwm high", n[15:0], exp_n[15:0]);
        wr(3'h2, 8'h55);
        rd(3'h2, d); check("held duty", {8'h00, d}, {8'h00, lo});
        wr(3'h0, 8'h00);
        check("pwm release", pin_oe, 0);
    endtask : pwm_run
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        results;
    end
    initial begin
        reg_defaults;
        cmp_mode(CPU_CMP_SET, 1'b1, 1'b1);
        cmp_mode(CPU_CMP_CLR, 1'b0, 1'b1);
        cmp_mode(CPU_CMP_TOG, 1'b1, 1'b1);
        cmp_mode(CPU_CMP_SWI, 1'b0, 1'b0);
        special_event;
        asleep;
        alt_pin;
        pwm_run(8'h04, 8'h01, 8'h2c, 64, 24);
        pwm_run(8'h04, 8'h01, 8'h1c, 64, 20);
        pwm_run(8'h05, 8'h01, 8'h2c, 256, 96);
        pwm_run(8'h04, 8'h00, 8'h0c, 64, 0);
        results;
    end
endmodule : tb_top
`default_nettype wire
